// [core/mgmt_interrupt_power_control.sv]
// management interrupt and processor power control with wishbone registers
// assumes inputs synchronous to clk; far side is the host processor
//
// Function
// - route bit picks controller or dedicated pin
// - routed interrupt takes shared local controller input
// - mask holds legacy interrupt output driven inactive
// - freeze bit stops idle timer, set at reset
// - scaling timers set halt high and low
// - power command read asserts halt when enabled
// - halt enable clear keeps halt request high
// - halt enable cleared by zero or command write
// - gate bit lets pending condition drive pin
// - closed gate still records events in status
// - pending event asserts pin once gate opens
// - sources work in normal and idle states
// - bit seven: command writes raise events
// - bit six: external request raises events
// - bit five: idle timer zero raises events
// - bit four: request line twelve raises events
// - bit three: request line eight raises events
// - hardware events reach pin only through gate
// - source enables reset disabled, upper bits reserved
// - bits two to zero: lines four, three, one
`timescale 1ns/10ps
module mgmt_interrupt_power_control #(
  parameter int TIMER_WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input mgmt_irq_pkg::wb_req_t wbReq,
  output logic wbAck,
  output logic [31:0] wbDatOut,
  input wire mgmt_irq_pkg::hw_irq_t hwIrq,
  input wire logic external_mgmt_req_n,
  input wire logic legacyIrqIn,
  output logic legacy_cpu_irq_out,
  output logic mgmt_irq_pin_n,
  output logic advancedLocalIrq,
  output logic clock_halt_req_n
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic route_select;
    logic legacy_irq_mask;
    logic [7:0] test;
    logic idle_timer_freeze;
    logic halt_scaling_enable;
    logic halt_signal_enable;
    logic mgmt_irq_gate;
    logic [7:0] srcEnable;
    logic [7:0] powerCmd;
    logic powerCmdWrite;
    logic [7:0] scaleHigh;
    logic [7:0] scaleLow;
    logic [TIMER_WIDTH-1:0] idleReload;
    logic [TIMER_WIDTH-1:0] idleCount;
    logic idleZero;
    logic haltActive;
    logic haltLowPhase;
    logic [7:0] scaleCount;
    logic pinN;
    logic localIrq;
    logic legacyOut;
    logic haltN;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic [7:0] pending;
  logic [7:0] srcLevel;
  logic [7:0] clearMask;
  logic access;
  logic [7:0] idx;
  logic pendingAny;
  logic [7:0] rdByte0;
  logic [31:0] rdWord;

  // one access per request, answered the next cycle
  assign access = wbReq.cyc & wbReq.stb & ~s_q.ack;
  assign idx = wbReq.adr[9:2];

  // source levels, all active high
  assign srcLevel[mgmt_irq_pkg::SRC_IRQ1] = hwIrq.irq1;
  assign srcLevel[mgmt_irq_pkg::SRC_IRQ3] = hwIrq.irq3;
  assign srcLevel[mgmt_irq_pkg::SRC_IRQ4] = hwIrq.irq4;
  assign srcLevel[mgmt_irq_pkg::SRC_IRQ8] = hwIrq.irq8;
  assign srcLevel[mgmt_irq_pkg::SRC_IRQ12] = hwIrq.irq12;
  assign srcLevel[mgmt_irq_pkg::SRC_IDLE_TIMER] = s_q.idleZero;
  assign srcLevel[mgmt_irq_pkg::SRC_EXTERNAL] = ~external_mgmt_req_n;
  assign srcLevel[mgmt_irq_pkg::SRC_POWER_CMD] = s_q.powerCmdWrite;

  // status clear: write one to clear, low byte lane
  assign clearMask = (access && wbReq.we && wbReq.sel[0]
                      && idx == mgmt_irq_pkg::IDX_STATUS) ? wbReq.dat[7:0] : 8'h00;

  // pending flags, independent of gate and power state
  mgmt_event_latch #(
    .N(mgmt_irq_pkg::NUM_SOURCES)
  ) u_latch (
    .clk(clk),
    .rst_n(rst_n),
    .srcLevel(srcLevel),
    .srcEnable(s_q.srcEnable),
    .clearMask(clearMask),
    .pending(pending)
  );

  assign pendingAny = |pending;

  // control register image
  assign rdByte0 = {1'b0, 3'b000, s_q.idle_timer_freeze, s_q.halt_scaling_enable,
                    s_q.halt_signal_enable, s_q.mgmt_irq_gate};

  // read multiplexer, narrow registers in the low bits
  always_comb
  begin
    rdWord = 32'h0000_0000;
    case (idx)
      mgmt_irq_pkg::IDX_ROUTING:
        rdWord[1:0] = {s_q.route_select, s_q.legacy_irq_mask};
      mgmt_irq_pkg::IDX_TEST:
        rdWord[7:0] = s_q.test;
      mgmt_irq_pkg::IDX_CONTROL:
        rdWord[7:0] = rdByte0;
      mgmt_irq_pkg::IDX_SRC_ENABLE:
        rdWord[7:0] = s_q.srcEnable;
      mgmt_irq_pkg::IDX_STATUS:
        rdWord[7:0] = pending;
      mgmt_irq_pkg::IDX_POWER_CMD:
        rdWord[7:0] = s_q.powerCmd;
      mgmt_irq_pkg::IDX_SCALE_HIGH:
        rdWord[7:0] = s_q.scaleHigh;
      mgmt_irq_pkg::IDX_SCALE_LOW:
        rdWord[7:0] = s_q.scaleLow;
      mgmt_irq_pkg::IDX_IDLE_RELOAD:
        rdWord[TIMER_WIDTH-1:0] = s_q.idleReload;
      default:
        rdWord = 32'h0000_0000;
    endcase
  end

  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.ack = access;
    s_d.powerCmdWrite = 1'b0;
    s_d.idleZero = 1'b0;
    if (access)
      s_d.rdata = wbReq.we ? 32'h0000_0000 : rdWord;

    // register writes, byte lanes honoured
    if (access && wbReq.we)
    begin
      case (idx)
        mgmt_irq_pkg::IDX_ROUTING:
          if (wbReq.sel[0])
          begin
            s_d.route_select = wbReq.dat[mgmt_irq_pkg::ROUTE_SELECT_BIT];
            s_d.legacy_irq_mask = wbReq.dat[mgmt_irq_pkg::LEGACY_MASK_BIT];
          end
        mgmt_irq_pkg::IDX_TEST:
          if (wbReq.sel[0])
            s_d.test = wbReq.dat[7:0];
        mgmt_irq_pkg::IDX_CONTROL:
          if (wbReq.sel[0])
          begin
            // bit seven is reserved and ignored
            s_d.idle_timer_freeze = wbReq.dat[mgmt_irq_pkg::CTL_FREEZE_BIT];
            s_d.halt_scaling_enable = wbReq.dat[mgmt_irq_pkg::CTL_SCALE_EN_BIT];
            s_d.halt_signal_enable = wbReq.dat[mgmt_irq_pkg::CTL_HALT_EN_BIT];
            s_d.mgmt_irq_gate = wbReq.dat[mgmt_irq_pkg::CTL_GATE_BIT];
          end
        mgmt_irq_pkg::IDX_SRC_ENABLE:
          if (wbReq.sel[0])
            s_d.srcEnable = wbReq.dat[7:0];
        mgmt_irq_pkg::IDX_POWER_CMD:
        begin
          if (wbReq.sel[0])
            s_d.powerCmd = wbReq.dat[7:0];
          s_d.powerCmdWrite = 1'b1;
          s_d.halt_signal_enable = 1'b0;
        end
        mgmt_irq_pkg::IDX_SCALE_HIGH:
          if (wbReq.sel[0])
            s_d.scaleHigh = wbReq.dat[7:0];
        mgmt_irq_pkg::IDX_SCALE_LOW:
          if (wbReq.sel[0])
            s_d.scaleLow = wbReq.dat[7:0];
        mgmt_irq_pkg::IDX_IDLE_RELOAD:
        begin
          if (wbReq.sel[0])
            s_d.idleReload[7:0] = wbReq.dat[7:0];
          if (wbReq.sel[1])
            s_d.idleReload[TIMER_WIDTH-1:8] = wbReq.dat[TIMER_WIDTH-1:8];
        end
        default:
          s_d.test = s_q.test;
      endcase
    end

    // idle powerdown timer, pulses when it reaches zero
    if (!s_q.idle_timer_freeze)
    begin
      if (s_q.idleCount == '0)
        s_d.idleCount = s_q.idleReload;
      else
      begin
        s_d.idleCount = s_q.idleCount - 1'b1;
        s_d.idleZero = (s_q.idleCount == TIMER_WIDTH'(1));
      end
    end
    // a reload write also restarts the count, so short periods take effect at once
    if (access && wbReq.we && idx == mgmt_irq_pkg::IDX_IDLE_RELOAD)
      s_d.idleCount = s_d.idleReload;

    // halt request: armed by a command port read
    if (access && !wbReq.we && idx == mgmt_irq_pkg::IDX_POWER_CMD
        && s_q.halt_signal_enable)
    begin
      s_d.haltActive = 1'b1;
      s_d.haltLowPhase = 1'b1;
      s_d.scaleCount = s_q.scaleLow;
    end
    else if (!s_d.halt_signal_enable)
      s_d.haltActive = 1'b0;
    else if (s_q.haltActive && s_q.halt_scaling_enable)
    begin
      if (s_q.scaleCount <= 8'h01)
      begin
        s_d.haltLowPhase = ~s_q.haltLowPhase;
        s_d.scaleCount = s_q.haltLowPhase ? s_q.scaleHigh : s_q.scaleLow;
      end
      else
        s_d.scaleCount = s_q.scaleCount - 8'h01;
    end
    s_d.haltN = ~(s_d.haltActive && (s_d.haltLowPhase || !s_q.halt_scaling_enable));

    // interrupt delivery
    s_d.pinN = ~(pendingAny && s_q.mgmt_irq_gate && !s_q.route_select);
    s_d.localIrq = s_q.route_select ? (pendingAny && s_q.mgmt_irq_gate)
                                    : legacyIrqIn;
    s_d.legacyOut = s_q.legacy_irq_mask ? 1'b0 : legacyIrqIn;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.route_select <= mgmt_irq_pkg::RST_ROUTING[mgmt_irq_pkg::ROUTE_SELECT_BIT];
      s_q.legacy_irq_mask <= mgmt_irq_pkg::RST_ROUTING[mgmt_irq_pkg::LEGACY_MASK_BIT];
      s_q.test <= mgmt_irq_pkg::RST_TEST;
      s_q.idle_timer_freeze <= mgmt_irq_pkg::RST_CONTROL[mgmt_irq_pkg::CTL_FREEZE_BIT];
      s_q.halt_scaling_enable <= mgmt_irq_pkg::RST_CONTROL[mgmt_irq_pkg::CTL_SCALE_EN_BIT];
      s_q.halt_signal_enable <= mgmt_irq_pkg::RST_CONTROL[mgmt_irq_pkg::CTL_HALT_EN_BIT];
      s_q.mgmt_irq_gate <= mgmt_irq_pkg::RST_CONTROL[mgmt_irq_pkg::CTL_GATE_BIT];
      s_q.srcEnable <= mgmt_irq_pkg::RST_SRC_ENABLE[7:0];
      s_q.scaleHigh <= mgmt_irq_pkg::RST_SCALE;
      s_q.scaleLow <= mgmt_irq_pkg::RST_SCALE;
      s_q.idleReload <= mgmt_irq_pkg::RST_IDLE_RELOAD[TIMER_WIDTH-1:0];
      s_q.idleCount <= mgmt_irq_pkg::RST_IDLE_RELOAD[TIMER_WIDTH-1:0];
      s_q.pinN <= 1'b1;
      s_q.haltN <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // outputs straight from flip-flops
  assign wbAck = s_q.ack;
  assign wbDatOut = s_q.rdata;
  assign mgmt_irq_pin_n = s_q.pinN;
  assign advancedLocalIrq = s_q.localIrq;
  assign legacy_cpu_irq_out = s_q.legacyOut;
  assign clock_halt_req_n = s_q.haltN;

endmodule

// [core/mgmt_irq_pkg.sv]
// shared constants and carrier types for the management interrupt block
// assumes a 32-bit classic wishbone master and one system clock
package mgmt_irq_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ROUTING = 8'h70;
  localparam logic [7:0] IDX_TEST = 8'h88;
  localparam logic [7:0] IDX_CONTROL = 8'ha0;
  localparam logic [7:0] IDX_SRC_ENABLE = 8'ha2;
  localparam logic [7:0] IDX_STATUS = 8'hb0;
  localparam logic [7:0] IDX_POWER_CMD = 8'hb1;
  localparam logic [7:0] IDX_SCALE_HIGH = 8'hb2;
  localparam logic [7:0] IDX_SCALE_LOW = 8'hb3;
  localparam logic [7:0] IDX_IDLE_RELOAD = 8'hb4;

  // routing control fields
  localparam int ROUTE_SELECT_BIT = 1;
  localparam int LEGACY_MASK_BIT = 0;

  // control register fields
  localparam int CTL_MUST_ZERO_BIT = 7;
  localparam int CTL_FREEZE_BIT = 3;
  localparam int CTL_SCALE_EN_BIT = 2;
  localparam int CTL_HALT_EN_BIT = 1;
  localparam int CTL_GATE_BIT = 0;

  // source enable / status bit positions
  localparam int SRC_IRQ1 = 0;
  localparam int SRC_IRQ3 = 1;
  localparam int SRC_IRQ4 = 2;
  localparam int SRC_IRQ8 = 3;
  localparam int SRC_IRQ12 = 4;
  localparam int SRC_IDLE_TIMER = 5;
  localparam int SRC_EXTERNAL = 6;
  localparam int SRC_POWER_CMD = 7;
  localparam int NUM_SOURCES = 8;

  // reset values
  localparam logic [7:0] RST_ROUTING = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h08;
  localparam logic [15:0] RST_SRC_ENABLE = 16'h0000;
  localparam logic [7:0] RST_SCALE = 8'h01;
  localparam logic [15:0] RST_IDLE_RELOAD = 16'hffff;

  // wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  // hardware interrupt request lines watched as sources
  typedef struct packed {
    logic irq12;
    logic irq8;
    logic irq4;
    logic irq3;
    logic irq1;
  } hw_irq_t;

endpackage

// [core/mgmt_event_latch.sv]
// sticky pending flags, one per management source
// assumes source levels are synchronous to clk, active high
`timescale 1ns/10ps
module mgmt_event_latch #(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [N-1:0] srcLevel,
  input wire logic [N-1:0] srcEnable,
  input wire logic [N-1:0] clearMask,
  output logic [N-1:0] pending
);

  typedef struct packed {
    logic [N-1:0] prev;
    logic [N-1:0] pend;
  } latch_state_t;

  latch_state_t s_q;
  latch_state_t s_d;
  logic [N-1:0] rise;

  // rising edge of each enabled source sets its flag; set beats clear
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : gen_src
      assign rise[g] = srcLevel[g] & ~s_q.prev[g] & srcEnable[g];
    end
  endgenerate

  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.prev = srcLevel;
    s_d.pend = (s_q.pend & ~clearMask) | rise;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pending = s_q.pend;

endmodule

// [tb/mgmt_irq_checker_assertions.sv]
// bus and pin relations of the management interrupt block
// assumes it is bound into mgmt_interrupt_power_control on one clock
`timescale 1ns/10ps
module mgmt_irq_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire mgmt_irq_pkg::wb_req_t wbReq,
  input wire logic wbAck,
  input wire logic [31:0] wbDatOut,
  input wire logic legacyIrqIn,
  input wire logic legacy_cpu_irq_out,
  input wire logic mgmt_irq_pin_n,
  input wire logic advancedLocalIrq,
  input wire logic clock_halt_req_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a request not yet answered
  sequence takeS;
    wbReq.cyc && wbReq.stb && !wbAck;
  endsequence
  // answer is one pulse
  sequence pulseS;
    wbAck ##1 !wbAck;
  endsequence
  // bus handshake and read data shape
  ack_once_a: assert property (takeS |=> pulseS)
    else $error("ack not a single pulse after request");
  ack_cause_a: assert property (!(wbReq.cyc && wbReq.stb) |=> !wbAck)
    else $error("ack without request");
  write_data_a: assert property (wbAck && $past(wbReq.we) |-> wbDatOut == 32'h0)
    else $error("write ack carries data");
  enable_upper_a: assert property (wbAck && $past(wbReq.adr[9:2]) ==
    mgmt_irq_pkg::IDX_SRC_ENABLE |-> wbDatOut[31:8] == 24'h0)
    else $error("reserved enable bits read nonzero");
  control_top_a: assert property (wbAck && $past(wbReq.adr[9:2]) ==
    mgmt_irq_pkg::IDX_CONTROL |-> wbDatOut[31:7] == 25'h0)
    else $error("control top bit reads nonzero");
  // pin relations
  legacy_mask_a: assert property (legacy_cpu_irq_out |-> $past(legacyIrqIn))
    else $error("legacy output high without input");
  pin_route_a: assert property (!mgmt_irq_pin_n |->
    advancedLocalIrq == $past(legacyIrqIn))
    else $error("pin asserted while routed to controller");
  halt_clear_a: assert property (wbAck && $past(wbReq.we) && $past(wbReq.adr[9:2]) ==
    mgmt_irq_pkg::IDX_POWER_CMD |=> clock_halt_req_n)
    else $error("halt request kept after command write");
endmodule
bind mgmt_interrupt_power_control mgmt_irq_checker chk (.clk(clk), .rst_n(rst_n),
  .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut), .legacyIrqIn(legacyIrqIn),
  .legacy_cpu_irq_out(legacy_cpu_irq_out), .mgmt_irq_pin_n(mgmt_irq_pin_n),
  .advancedLocalIrq(advancedLocalIrq), .clock_halt_req_n(clock_halt_req_n));

// [tb/host_cpu_model.sv]
// host processor stand-in counting management interrupt entries
// assumes the pin is a registered level on the system clock
`timescale 1ns/10ps
module host_cpu_model (
  input wire logic clk,
  input wire logic mgmt_irq_pin_n,
  output logic [7:0] irqCount
);
  logic pinQ;
  initial irqCount = 8'h0;
  // count falling edges of the pin
  always @(posedge clk)
  begin
    pinQ <= mgmt_irq_pin_n;
    if (pinQ && !mgmt_irq_pin_n)
      irqCount <= irqCount + 8'h1;
  end
endmodule

// [tb/tb_top.sv]
// register level bench for the management interrupt block
// assumes one 125 MHz clock and classic wishbone access
`timescale 1ns/10ps
module tb_top;
  logic clk, rst_n, wbAck, extReqN, legacyIrqIn, legacyOut, pinN, advIrq, haltN;
  logic [31:0] wbDatOut, rdat;
  logic [7:0] cpuIrqs;
  mgmt_irq_pkg::wb_req_t wbReq;
  mgmt_irq_pkg::hw_irq_t hwIrq;
  int n_fail, check_count, n;
  mgmt_interrupt_power_control dut (.clk(clk), .rst_n(rst_n), .wbReq(wbReq),
    .wbAck(wbAck), .wbDatOut(wbDatOut), .hwIrq(hwIrq), .external_mgmt_req_n(extReqN),
    .legacyIrqIn(legacyIrqIn), .legacy_cpu_irq_out(legacyOut), .mgmt_irq_pin_n(pinN),
    .advancedLocalIrq(advIrq), .clock_halt_req_n(haltN));
  host_cpu_model cpu (.clk(clk), .mgmt_irq_pin_n(pinN), .irqCount(cpuIrqs));
  // compare and count
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle, held until ack
  task automatic wb(logic we, logic [7:0] idx, logic [31:0] wd);
    wbReq <= '{1'b1, 1'b1, we, {2'b00, idx, 2'b00}, 4'hf, wd};
    do @(posedge clk); while (wbAck !== 1'b1);
    rdat = wbDatOut;
    wbReq <= '0;
    @(posedge clk);
  endtask
  task automatic wr(logic [7:0] idx, logic [31:0] d);
    wb(1'b1, idx, d);
  endtask
  task automatic rdc(logic [7:0] idx, logic [31:0] exp);
    wb(1'b0, idx, 32'h0);
    check($sformatf("reg %h", idx), rdat, exp);
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk);
  endtask
  // raise one management source; g keeps the gate for the timer case
  task automatic fire(int i, logic g);
    if (i < 5)
    begin
      hwIrq <= mgmt_irq_pkg::hw_irq_t'(5'(1 << i));
      tick(2);
      hwIrq <= '0;
    end
    else if (i == 6)
    begin
      extReqN <= 1'b0;
      tick(2);
      extReqN <= 1'b1;
    end
    else if (i == 7)
      wr(mgmt_irq_pkg::IDX_POWER_CMD, 32'h0);
    else
    begin
      wr(mgmt_irq_pkg::IDX_CONTROL, {31'h0, g});
      tick(8);
      wr(mgmt_irq_pkg::IDX_CONTROL, {28'h0, 1'b1, 2'b00, g});
    end
  endtask
  task automatic runLen(logic v);
    n = 0;
    while (haltN === v && n < 50)
    begin
      n++;
      @(posedge clk);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // watchdog
  initial
  begin
    tick(4000);
    n_fail++;
    close_out();
  end
  // main sequence
  initial
  begin
    {rst_n, wbReq, hwIrq, legacyIrqIn} = '0;
    extReqN = 1'b1;
    tick(8);
    rst_n <= 1'b1;
    rdc(mgmt_irq_pkg::IDX_ROUTING, 32'h0);
    rdc(mgmt_irq_pkg::IDX_TEST, 32'h0);
    rdc(mgmt_irq_pkg::IDX_CONTROL, 32'h8);
    rdc(mgmt_irq_pkg::IDX_SRC_ENABLE, 32'h0);
    rdc(8'h10, 32'h0);
    wr(mgmt_irq_pkg::IDX_SRC_ENABLE, 32'hffff);
    rdc(mgmt_irq_pkg::IDX_SRC_ENABLE, 32'hff);
    wr(mgmt_irq_pkg::IDX_IDLE_RELOAD, 32'h4);
    for (int i = 0; i < 8; i++)
    begin
      wr(mgmt_irq_pkg::IDX_SRC_ENABLE, 32'h0);
      wr(mgmt_irq_pkg::IDX_CONTROL, 32'h9);
      fire(i, 1'b1);
      tick(3);
      check("pin idle", pinN, 1'b1);
      rdc(mgmt_irq_pkg::IDX_STATUS, 32'h0);
      wr(mgmt_irq_pkg::IDX_SRC_ENABLE, 32'(1 << i));
      wr(mgmt_irq_pkg::IDX_CONTROL, 32'h8);
      fire(i, 1'b0);
      tick(3);
      check("pin gated", pinN, 1'b1);
      rdc(mgmt_irq_pkg::IDX_STATUS, 32'(1 << i));
      wr(mgmt_irq_pkg::IDX_CONTROL, 32'h9);
      tick(1);
      check("pin on gate", pinN, 1'b0);
      wr(mgmt_irq_pkg::IDX_STATUS, 32'(1 << i));
      tick(1);
      check("pin cleared", pinN, 1'b1);
    end
    // mask and routing; controller taken as enabled before masking
    legacyIrqIn <= 1'b1;
    tick(2);
    check("legacy pass", legacyOut, 1'b1);
    wr(mgmt_irq_pkg::IDX_ROUTING, 32'h1);
    check("legacy masked", legacyOut, 1'b0);
    wr(mgmt_irq_pkg::IDX_SRC_ENABLE, 32'h1);
    wr(mgmt_irq_pkg::IDX_ROUTING, 32'h2);
    check("local no legacy", advIrq, 1'b0);
    check("legacy back", legacyOut, 1'b1);
    fire(0, 1'b1);
    tick(3);
    check("pin routed away", pinN, 1'b1);
    check("local event", advIrq, 1'b1);
    wr(mgmt_irq_pkg::IDX_ROUTING, 32'h0);
    tick(1);
    check("pin routed back", pinN, 1'b0);
    check("local legacy", advIrq, 1'b1);
    wr(mgmt_irq_pkg::IDX_STATUS, 32'h1);
    // processor clock halt
    wr(mgmt_irq_pkg::IDX_CONTROL, 32'ha);
    rdc(mgmt_irq_pkg::IDX_POWER_CMD, 32'h0);
    check("halt on read", haltN, 1'b0);
    wr(mgmt_irq_pkg::IDX_POWER_CMD, 32'h0);
    check("halt off write", haltN, 1'b1);
    wr(mgmt_irq_pkg::IDX_CONTROL, 32'ha);
    rdc(mgmt_irq_pkg::IDX_POWER_CMD, 32'h0);
    wr(mgmt_irq_pkg::IDX_CONTROL, 32'h8);
    check("halt off zero", haltN, 1'b1);
    rdc(mgmt_irq_pkg::IDX_POWER_CMD, 32'h0);
    check("halt disabled", haltN, 1'b1);
    wr(mgmt_irq_pkg::IDX_SCALE_LOW, 32'h3);
    wr(mgmt_irq_pkg::IDX_SCALE_HIGH, 32'h2);
    wr(mgmt_irq_pkg::IDX_CONTROL, 32'he);
    rdc(mgmt_irq_pkg::IDX_POWER_CMD, 32'h0);
    runLen(1'b0);
    runLen(1'b1);
    check("high time", n, 32'h2);
    runLen(1'b0);
    check("low time", n, 32'h3);
    wr(mgmt_irq_pkg::IDX_POWER_CMD, 32'h0);
    check("cpu entries", {24'h0, cpuIrqs}, 32'h9);
    close_out();
  end
endmodule
